// ===== rtl/dtix_params.svh
// Constants for the data-transfer instruction executor: offsets, fields, resets, opcodes, timing.
`ifndef DTIX_PARAMS_SVH
`define DTIX_PARAMS_SVH

// Register byte offsets on the APB.
`define DTIX_OFF_CMD      12'h000
`define DTIX_OFF_STATUS   12'h004
`define DTIX_OFF_FLAGS    12'h008
`define DTIX_OFF_WREG     12'h00C

// Field positions.
`define DTIX_CMD_OP_MSB   15
`define DTIX_CMD_OP_LSB   8
`define DTIX_CMD_OPD_MSB  7
`define DTIX_CMD_OPD_LSB  0
`define DTIX_ST_BUSY      0
`define DTIX_ST_BADOP     1
`define DTIX_FL_NULL      0
`define DTIX_FL_RIPPLE    1
`define DTIX_FL_NIBBLE    2
`define DTIX_FL_SRANGE    3

// Reset values.
`define DTIX_RST_WREG     8'h00
`define DTIX_RST_FLAGS    4'h0
`define DTIX_RST_CMD      16'h0000

// Opcodes written into the command register.
`define DTIX_OP_LDI       8'h01
`define DTIX_OP_STM       8'h02
`define DTIX_OP_LDM       8'h03
`define DTIX_OP_LDIO      8'h04
`define DTIX_OP_STIO      8'h05
`define DTIX_OP_TABH      8'h06
`define DTIX_OP_TABL      8'h07
`define DTIX_OP_TCAP      8'h08
`define DTIX_OP_TPRE      8'h09

// Instruction cycles per move kind.
`define DTIX_CYC_MOVE     1
`define DTIX_CYC_TAB      2

`endif

// ===== rtl/dtix_pkg.sv
// Types shared by the data-transfer instruction executor.
`default_nettype none
package dtix_pkg;

    // Execution sequencer states.
    typedef enum logic [1:0] {
        DTIX_IDLE,
        DTIX_EXEC1,
        DTIX_EXEC2
    } dtix_state_t;

endpackage
`default_nettype wire

// ===== rtl/dtix_ram.sv
// Byte-wide data memory with a paired word port for two-byte operands.
`default_nettype none
module dtix_ram #(
    parameter int AW = 8                          // Address width in bits, one byte per address.
) (
    input  wire logic          clk,               // System clock.
    input  wire logic          rst_n,             // Async reset, clears read registers.
    input  wire logic [AW-1:0] addr,              // Byte address of the low byte.
    input  wire logic          we_lo,             // Write the byte at addr.
    input  wire logic          we_hi,             // Write the byte at addr plus one.
    input  wire logic [7:0]    wdata_lo,          // Data for the low byte.
    input  wire logic [7:0]    wdata_hi,          // Data for the high byte.
    output logic      [7:0]    rdata_lo,          // Registered byte at addr.
    output logic      [7:0]    rdata_hi           // Registered byte at addr plus one.
);

    logic [7:0]    mem [2**AW];
    logic [AW-1:0] addr_hi;

    // The high byte of a word sits at the next address, wrapping at the top.
    assign addr_hi = addr + {{(AW-1){1'b0}}, 1'b1};

    ////////////////////////////////////////////////////////////////////////////////
    // Writes of either byte lane.
    always_ff @(posedge clk) begin
        if (we_lo) begin
            mem[addr] <= wdata_lo;
        end
        if (we_hi) begin
            mem[addr_hi] <= wdata_hi;
        end
    end

    // Registered reads so the word is stable for the whole next cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_lo <= 8'h00;
            rdata_hi <= 8'h00;
        end else begin
            rdata_lo <= mem[addr];
            rdata_hi <= mem[addr_hi];
        end
    end

endmodule
`default_nettype wire

// ===== rtl/dtix_exec.sv
// Data-transfer instruction executor with an APB command and status slave.
//
// Decided for this implementation: the APB register port and the register addresses.
`include "dtix_params.svh"
`default_nettype none
module dtix_exec #(
    parameter int DMEM_AW = 8                     // Data memory address width.
) (
    input  wire logic        pclk,                // System clock, 25 MHz.
    input  wire logic        presetn,             // Async reset, active low.
    input  wire logic        psel,                // APB select.
    input  wire logic        penable,             // APB access phase.
    input  wire logic        pwrite,              // APB direction, high for write.
    input  wire logic [11:0] paddr,               // APB byte address.
    input  wire logic [31:0] pwdata,              // APB write data.
    output logic      [31:0] prdata,              // APB read data.
    output logic             pready,              // APB ready, always high.
    output logic             pslverr,             // APB error on refused access.
    output logic      [7:0]  io_addr,             // I/O register address.
    output logic      [7:0]  io_wdata,            // I/O write data.
    output logic             io_wr,               // I/O write strobe.
    output logic             io_rd,               // I/O read strobe.
    input  wire logic [7:0]  io_rdata,            // I/O read data, same cycle as io_rd.
    output logic      [15:0] prog_addr,           // Program memory word address.
    output logic             prog_rd,             // Program memory read strobe.
    input  wire logic [15:0] prog_rdata,          // Program word, valid one cycle later.
    input  wire logic [15:0] tmr_count,           // Current count of the 16-bit counter.
    output logic             tmr_load,            // Counter preload strobe.
    output logic      [15:0] tmr_load_val,        // Counter preload value.
    output logic             busy                 // An instruction is executing.
);

    dtix_pkg::dtix_state_t state_r;
    dtix_pkg::dtix_state_t state_nxt;

    logic [7:0]  working_register_r;
    logic [3:0]  flags_r;
    logic [7:0]  opcode_r;
    logic [7:0]  operand_r;
    logic        bad_op_r;
    logic        table_high_r;

    logic        apb_acc;
    logic        hit_cmd;
    logic        hit_status;
    logic        hit_flags;
    logic        hit_wreg;
    logic        idle;
    logic        start;
    logic        bad_start;
    logic [7:0]  new_op;
    logic [7:0]  ram_addr;
    logic        ram_we_lo;
    logic        ram_we_hi;
    logic [7:0]  ram_wdata_lo;
    logic [7:0]  ram_wdata_hi;
    logic [7:0]  ram_rdata_lo;
    logic [7:0]  ram_rdata_hi;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Result-null value for a byte result.
    function automatic logic is_null(input logic [7:0] value);
        is_null = (value == 8'h00);
    endfunction

    // True for any opcode this block knows how to execute.
    function automatic logic op_known(input logic [7:0] op);
        op_known = (op >= `DTIX_OP_LDI) && (op <= `DTIX_OP_TPRE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode. The slave never waits, so every access ends in its first access cycle.
    assign pready     = 1'b1;
    assign apb_acc    = psel && penable;
    assign hit_cmd    = (paddr == `DTIX_OFF_CMD);
    assign hit_status = (paddr == `DTIX_OFF_STATUS);
    assign hit_flags  = (paddr == `DTIX_OFF_FLAGS);
    assign hit_wreg   = (paddr == `DTIX_OFF_WREG);
    assign idle       = (state_r == dtix_pkg::DTIX_IDLE);
    assign busy       = !idle;
    assign new_op     = pwdata[`DTIX_CMD_OP_MSB:`DTIX_CMD_OP_LSB];
    assign start      = apb_acc && pwrite && hit_cmd && idle && op_known(new_op);
    assign bad_start  = apb_acc && pwrite && hit_cmd && idle && !op_known(new_op);

    // Refused: unmapped address, write to status, unknown opcode, or any write while busy.
    always_comb begin
        pslverr = 1'b0;
        if (apb_acc) begin
            if (!(hit_cmd || hit_status || hit_flags || hit_wreg)) begin
                pslverr = 1'b1;
            end else if (pwrite && hit_status) begin
                pslverr = 1'b1;
            end else if (pwrite && !idle) begin
                pslverr = 1'b1;
            end else if (bad_start) begin
                pslverr = 1'b1;
            end
        end
    end

    // Read data mux; unmapped addresses read zero.
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit_cmd) begin
            prdata[15:0] = {opcode_r, operand_r};
        end else if (hit_status) begin
            prdata[`DTIX_ST_BUSY]  = busy;
            prdata[`DTIX_ST_BADOP] = bad_op_r;
        end else if (hit_flags) begin
            prdata[3:0] = flags_r;
        end else if (hit_wreg) begin
            prdata[7:0] = working_register_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command capture; the operand is an immediate, a byte address or a word address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opcode_r  <= 8'(`DTIX_RST_CMD >> 8);
            operand_r <= 8'h00;
        end else if (start) begin
            opcode_r  <= new_op;
            operand_r <= pwdata[`DTIX_CMD_OPD_MSB:`DTIX_CMD_OPD_LSB];
        end
    end

    // Unknown opcode indication, cleared by the next accepted command.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bad_op_r <= 1'b0;
        end else if (bad_start) begin
            bad_op_r <= 1'b1;
        end else if (start) begin
            bad_op_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer: every move is one cycle, table reads take a second one.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            dtix_pkg::DTIX_IDLE: begin
                if (start) begin
                    state_nxt = dtix_pkg::DTIX_EXEC1;
                end
            end
            dtix_pkg::DTIX_EXEC1: begin
                if (opcode_r == `DTIX_OP_TABH || opcode_r == `DTIX_OP_TABL) begin
                    state_nxt = dtix_pkg::DTIX_EXEC2;
                end else begin
                    state_nxt = dtix_pkg::DTIX_IDLE;
                end
            end
            dtix_pkg::DTIX_EXEC2: begin
                state_nxt = dtix_pkg::DTIX_IDLE;
            end
            default: begin
                state_nxt = dtix_pkg::DTIX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= dtix_pkg::DTIX_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data memory. The address comes straight from the command write so the
    // operand byte or word is already registered when the first cycle begins.
    assign ram_addr     = start ? pwdata[`DTIX_CMD_OPD_MSB:`DTIX_CMD_OPD_LSB] : operand_r;
    assign ram_we_lo    = (state_r == dtix_pkg::DTIX_EXEC1)
                          && (opcode_r == `DTIX_OP_STM || opcode_r == `DTIX_OP_TCAP);
    assign ram_we_hi    = (state_r == dtix_pkg::DTIX_EXEC1) && (opcode_r == `DTIX_OP_TCAP);
    assign ram_wdata_lo = (opcode_r == `DTIX_OP_TCAP) ? tmr_count[7:0]
                                                      : working_register_r;
    assign ram_wdata_hi = tmr_count[15:8];

    dtix_ram #(
        .AW (DMEM_AW)
    ) u_ram (
        .clk      (pclk),
        .rst_n    (presetn),
        .addr     (ram_addr[DMEM_AW-1:0]),
        .we_lo    (ram_we_lo),
        .we_hi    (ram_we_hi),
        .wdata_lo (ram_wdata_lo),
        .wdata_hi (ram_wdata_hi),
        .rdata_lo (ram_rdata_lo),
        .rdata_hi (ram_rdata_hi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // I/O space strobes; address and write data come from flops.
    assign io_addr  = operand_r;
    assign io_wdata = working_register_r;
    assign io_wr    = (state_r == dtix_pkg::DTIX_EXEC1) && (opcode_r == `DTIX_OP_STIO);
    assign io_rd    = (state_r == dtix_pkg::DTIX_EXEC1) && (opcode_r == `DTIX_OP_LDIO);

    // Program memory: the pointer word is read from data memory, low byte first.
    assign prog_addr = {ram_rdata_hi, ram_rdata_lo};
    assign prog_rd   = (state_r == dtix_pkg::DTIX_EXEC1)
                       && (opcode_r == `DTIX_OP_TABH || opcode_r == `DTIX_OP_TABL);

    // Counter preload from the memory word, low byte at the lower address.
    assign tmr_load_val = {ram_rdata_hi, ram_rdata_lo};
    assign tmr_load     = (state_r == dtix_pkg::DTIX_EXEC1) && (opcode_r == `DTIX_OP_TPRE);

    // Remember which half a table read wants, for the second cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            table_high_r <= 1'b0;
        end else if (state_r == dtix_pkg::DTIX_EXEC1) begin
            table_high_r <= (opcode_r == `DTIX_OP_TABH);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Working register: software may load it while idle, instructions update it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            working_register_r <= `DTIX_RST_WREG;
        end else if (idle && apb_acc && pwrite && hit_wreg) begin
            working_register_r <= pwdata[7:0];
        end else if (state_r == dtix_pkg::DTIX_EXEC1) begin
            if (opcode_r == `DTIX_OP_LDI) begin
                working_register_r <= operand_r;
            end else if (opcode_r == `DTIX_OP_LDM) begin
                working_register_r <= ram_rdata_lo;
            end else if (opcode_r == `DTIX_OP_LDIO) begin
                working_register_r <= io_rdata;
            end
        end else if (state_r == dtix_pkg::DTIX_EXEC2) begin
            if (table_high_r) begin
                working_register_r <= prog_rdata[15:8];
            end else begin
                working_register_r <= prog_rdata[7:0];
            end
        end
    end

    // Flags: software may load them while idle; of the instructions only memory and I/O loads touch result-null.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= `DTIX_RST_FLAGS;
        end else if (idle && apb_acc && pwrite && hit_flags) begin
            flags_r <= pwdata[3:0];
        end else if (state_r == dtix_pkg::DTIX_EXEC1) begin
            if (opcode_r == `DTIX_OP_LDM) begin
                flags_r[`DTIX_FL_NULL] <= is_null(ram_rdata_lo);
            end else if (opcode_r == `DTIX_OP_LDIO) begin
                flags_r[`DTIX_FL_NULL] <= is_null(io_rdata);
            end
        end
    end

endmodule
`default_nettype wire

// ===== verif/dtix_exec_checker.sv
// Concurrent checks on the ports of the data-transfer instruction executor.
`include "dtix_params.svh"
`default_nettype none
module dtix_exec_checker (
    input wire logic        pclk,     // System clock.
    input wire logic        presetn,  // Async reset, active low.
    input wire logic        psel,     // APB select.
    input wire logic        penable,  // APB access phase.
    input wire logic        pwrite,   // APB direction.
    input wire logic [11:0] paddr,    // APB address.
    input wire logic [31:0] pwdata,   // APB write data.
    input wire logic [7:0]  io_addr,  // I/O address.
    input wire logic        io_wr,    // I/O write strobe.
    input wire logic        io_rd,    // I/O read strobe.
    input wire logic        prog_rd,  // Program read strobe.
    input wire logic        tmr_load, // Counter preload strobe.
    input wire logic        busy      // Executing.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    // An accepted command write carrying either of two opcodes.
    sequence s_cmd(logic [7:0] a, logic [7:0] b);
        psel && penable && pwrite && !busy && paddr == `DTIX_OFF_CMD
            && (pwdata[15:8] == a || pwdata[15:8] == b);
    endsequence
    // Execution that lasts one cycle or two.
    sequence s_one;
        busy ##1 !busy;
    endsequence
    sequence s_two;
        busy ##1 busy ##1 !busy;
    endsequence
    AST_LDI_ONE: assert property (s_cmd(`DTIX_OP_LDI, `DTIX_OP_LDI) |=>
        (!io_wr && !io_rd && !prog_rd && !tmr_load) ##0 s_one) else $error("ldi wrong");
    AST_STM_ONE: assert property (s_cmd(`DTIX_OP_STM, `DTIX_OP_STM) |=>
        (!io_wr && !tmr_load) ##0 s_one) else $error("store wrong");
    AST_LDM_ONE: assert property (s_cmd(`DTIX_OP_LDM, `DTIX_OP_LDM) |=>
        (!io_rd && !prog_rd) ##0 s_one) else $error("load wrong");
    AST_LDIO_READ: assert property (s_cmd(`DTIX_OP_LDIO, `DTIX_OP_LDIO) |=>
        (io_rd && io_addr == $past(pwdata[7:0])) ##0 s_one) else $error("io read wrong");
    AST_STIO_WRITE: assert property (s_cmd(`DTIX_OP_STIO, `DTIX_OP_STIO) |=>
        (io_wr && io_addr == $past(pwdata[7:0])) ##0 s_one) else $error("io write wrong");
    AST_TAB_TWO: assert property (s_cmd(`DTIX_OP_TABH, `DTIX_OP_TABL) |=>
        prog_rd ##0 s_two) else $error("table read wrong");
    AST_TAB_PULSE: assert property (prog_rd |=> !prog_rd && busy)
        else $error("table strobe wrong");
    AST_TCAP_ONE: assert property (s_cmd(`DTIX_OP_TCAP, `DTIX_OP_TCAP) |=>
        (!tmr_load && !prog_rd) ##0 s_one) else $error("capture wrong");
    AST_TPRE_LOAD: assert property (s_cmd(`DTIX_OP_TPRE, `DTIX_OP_TPRE) |=>
        tmr_load ##1 !tmr_load && !busy) else $error("preload wrong");
endmodule
`default_nettype wire

// ===== verif/dtix_partner.sv
// Model of the I/O space, program memory and counter around the executor.
`default_nettype none
module dtix_partner #(
    parameter logic [15:0] TMR_INIT = 16'h1234 // Counter value after reset.
) (
    input  wire logic        pclk,        // System clock.
    input  wire logic        presetn,     // Async reset, active low.
    input  wire logic [7:0]  io_addr,     // I/O address.
    input  wire logic [7:0]  io_wdata,    // I/O write data.
    input  wire logic        io_wr,       // I/O write strobe.
    input  wire logic        io_rd,       // I/O read strobe.
    output logic      [7:0]  io_rdata,    // I/O read data.
    input  wire logic [15:0] prog_addr,   // Program word address.
    input  wire logic        prog_rd,     // Program read strobe.
    output logic      [15:0] prog_rdata,  // Program word, one cycle late.
    output logic      [15:0] tmr_count,   // Counter value.
    input  wire logic        tmr_load,    // Counter preload strobe.
    input  wire logic [15:0] tmr_load_val // Counter preload value.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  io_mem [256];
    logic        rd_q;
    logic [15:0] word_q;
    ////////////////////////////////////////////////////////////
    // I/O registers start at a known pattern; a write lands at the strobe's edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 256; i++) begin
                io_mem[i] <= 8'(i) ^ 8'h3C;
            end
        end else if (io_wr) begin
            io_mem[io_addr] <= io_wdata;
        end
    end
    // Read data is good only in the strobe cycle; otherwise the inverse shows.
    assign io_rdata = io_rd ? io_mem[io_addr] : ~io_mem[io_addr];
    // Program words answer one cycle after the strobe and are scrambled outside it.
    always_ff @(posedge pclk) begin
        rd_q <= prog_rd;
        word_q <= prog_addr ^ 16'h5AC3;
    end
    assign prog_rdata = rd_q ? word_q : ~word_q;
    // The counter is held still so that a capture sees a known count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr_count <= TMR_INIT;
        end else if (tmr_load) begin
            tmr_count <= tmr_load_val;
        end
    end
endmodule
`default_nettype wire

// ===== verif/test_data_transfer_instr_exec.sv
// Self-checking bench for the data-transfer instruction executor.
`include "dtix_params.svh"
`default_nettype none
module test_data_transfer_instr_exec;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] opd;
        logic [7:0] wreg;
        logic [3:0] fl;
    } dtix_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, io_wr, io_rd, prog_rd, tmr_load, busy, err;
    logic [7:0]  io_addr, io_wdata, io_rdata;
    logic [15:0] prog_addr, prog_rdata, tmr_count, tmr_load_val;
    logic        chained = 1'b0;
    int          fail_count = 0;
    int          total_checks = 0;
    dtix_row_t   rows [22] = '{
        '{`DTIX_OP_LDI, 8'hA5, 8'hA5, 4'hE}, '{`DTIX_OP_STM, 8'h10, 8'hA5, 4'hE},
        '{`DTIX_OP_LDI, 8'h00, 8'h00, 4'hE}, '{`DTIX_OP_STM, 8'h11, 8'h00, 4'hE},
        '{`DTIX_OP_LDM, 8'h11, 8'h00, 4'hF}, '{`DTIX_OP_LDI, 8'h5C, 8'h5C, 4'hF},
        '{`DTIX_OP_LDM, 8'h10, 8'hA5, 4'hE}, '{`DTIX_OP_LDIO, 8'h3C, 8'h00, 4'hF},
        '{`DTIX_OP_LDIO, 8'h01, 8'h3D, 4'hE}, '{`DTIX_OP_STIO, 8'h20, 8'h3D, 4'hE},
        '{`DTIX_OP_LDI, 8'h00, 8'h00, 4'hE}, '{`DTIX_OP_LDIO, 8'h20, 8'h3D, 4'hE},
        '{`DTIX_OP_LDM, 8'h11, 8'h00, 4'hF}, '{`DTIX_OP_TABH, 8'h10, 8'h5A, 4'hF},
        '{`DTIX_OP_TABL, 8'h10, 8'h66, 4'hF}, '{`DTIX_OP_TCAP, 8'h30, 8'h66, 4'hF},
        '{`DTIX_OP_LDM, 8'h30, 8'h34, 4'hE}, '{`DTIX_OP_LDM, 8'h31, 8'h12, 4'hE},
        '{`DTIX_OP_TPRE, 8'h10, 8'h12, 4'hE}, '{`DTIX_OP_TCAP, 8'h32, 8'h12, 4'hE},
        '{`DTIX_OP_LDM, 8'h33, 8'h00, 4'hF}, '{`DTIX_OP_LDM, 8'h32, 8'hA5, 4'hE}};
    ////////////////////////////////////////////////////////////
    // Clock of 40 ns period.
    always #20 pclk = ~pclk;
    dtix_exec dtix_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
        .io_rd(io_rd), .io_rdata(io_rdata), .prog_addr(prog_addr), .prog_rd(prog_rd),
        .prog_rdata(prog_rdata), .tmr_count(tmr_count), .tmr_load(tmr_load),
        .tmr_load_val(tmr_load_val), .busy(busy));
    dtix_partner dtix_partner_inst (.pclk(pclk), .presetn(presetn), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
        .tmr_count(tmr_count), .tmr_load(tmr_load), .tmr_load_val(tmr_load_val));
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Compares a seen value with the expected one.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer; with more set, the next setup follows at once.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic more);
        int n;
        if (!chained) begin
            @(posedge pclk);
        end
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            fail_count++;
            summarize();
        end
        penable <= 1'b0;
        if (!more) begin
            psel <= 1'b0;
        end
        chained = more;
    endtask
    // Waits, within a bound, for the executor to go idle.
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (busy !== 1'b0 && n < 20);
        if (busy !== 1'b0) begin
            fail_count++;
            summarize();
        end
    endtask
    // Table of moves, then back-to-back, refusals and a second reset.
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `DTIX_OFF_FLAGS, 32'hE, 1'b0);
        foreach (rows[i]) begin
            apb(1'b1, `DTIX_OFF_CMD, {16'h0, rows[i].op, rows[i].opd}, 1'b0);
            wait_idle();
            apb(1'b0, `DTIX_OFF_WREG, 32'h0, 1'b0);
            chk(rd, {24'h0, rows[i].wreg});
            apb(1'b0, `DTIX_OFF_FLAGS, 32'h0, 1'b0);
            chk(rd, {28'h0, rows[i].fl});
        end
        apb(1'b1, `DTIX_OFF_CMD, {16'h0, `DTIX_OP_TABL, 8'h10}, 1'b1);
        apb(1'b1, `DTIX_OFF_WREG, 32'h77, 1'b0);
        chk({31'h0, err}, 32'h1);
        wait_idle();
        apb(1'b0, `DTIX_OFF_WREG, 32'h0, 1'b0);
        chk(rd, 32'h66);
        apb(1'b1, `DTIX_OFF_CMD, 32'hFF00, 1'b0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, `DTIX_OFF_STATUS, 32'h0, 1'b0);
        chk(rd, 32'h2);
        apb(1'b1, `DTIX_OFF_STATUS, 32'h3, 1'b0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, `DTIX_OFF_CMD, {16'h0, `DTIX_OP_TABH, 8'h10}, 1'b1);
        apb(1'b0, `DTIX_OFF_STATUS, 32'h0, 1'b0);
        chk(rd, 32'h1);
        wait_idle();
        apb(1'b0, `DTIX_OFF_WREG, 32'h0, 1'b0);
        chk(rd, 32'h5A);
        apb(1'b0, `DTIX_OFF_FLAGS, 32'h0, 1'b0);
        chk(rd, 32'hE);
        apb(1'b0, 12'h010, 32'h0, 1'b0);
        chk({31'h0, err}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DTIX_OFF_WREG, 32'h0, 1'b0);
        chk(rd, 32'h0);
        apb(1'b0, `DTIX_OFF_FLAGS, 32'h0, 1'b0);
        chk(rd, 32'h0);
        apb(1'b0, `DTIX_OFF_STATUS, 32'h0, 1'b0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule
bind dtix_exec dtix_exec_checker dtix_exec_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .prog_rd(prog_rd),
    .tmr_load(tmr_load), .busy(busy));
`default_nettype wire
